// File: hdl/cell_acquisition_sequencer_regs.vh
`ifndef CELL_ACQUISITION_SEQUENCER_REGS_VH
`define CELL_ACQUISITION_SEQUENCER_REGS_VH

// System clock rate in hertz (200 MHz, 5 ns period).
`define SYS_CLK_HZ 200000000
// State machine oscillator rate in hertz.
`define FSM_OSC_HZ 16000000
// Timer oscillator rate in hertz.
`define TIMER_OSC_HZ 32768
// Accumulator width that holds the fractional rate dividers.
`define RATE_ACC_BITS 29

// Number of cell channels and of auxiliary channels.
`define CELL_CHANNELS 12
`define AUX_CHANNELS 2
// Index of the first auxiliary channel in the channel numbering.
`define AUX_FIRST 4'h0_00C
// Width of one converter code.
`define CODE_BITS 12
// Width of an averaged measurement.
`define MEAS_BITS 14
// Width of every register word.
`define WORD_BITS 16
// Width of a per-cell accumulator: 12-bit code, two scans, 128 cycles.
`define ACC_BITS 20
// Largest oversampling exponent (2 to the 7th is 128 cycles).
`define OVS_MAX_LOG2 3'h7

// Field positions in the enable mask.
`define MASK_CELL_MSB 11
`define MASK_AUX_LSB 12
`define MASK_AUX_MSB 13

// Field positions in the second identity word.
`define ID2_CRC_MSB 15
`define ID2_CRC_LSB 8

// Calibration ROM: populated indices are 0 to 10 and 15.
`define CALIB_WORDS 12
`define CALIB_LAST_LOW 4'h0_00A
`define CALIB_LAST_INDEX 4'h0_00F
// Polynomial of the calibration checksum (x^8 + x^2 + x + 1).
`define CALIB_CRC_POLY 8'h07

// Reset values.
`define RESULT_RESET 16'h0000
`define TIMER_RESET 16'h0000

`endif

// File: hdl/rate_tick.v
`timescale 1ns/1ps

// Fractional divider: emits a one-cycle enable at NUM/DEN of the clock rate.
// The long-term average rate is exact; single periods jitter by one cycle.
module rate_tick #(
   parameter NUM = 1,
   parameter DEN = 2,
   parameter WIDTH = 29
) (
   input wire clk,
   input wire reset,
   output reg tick
);

   // Constants sized to the phase arithmetic.
   localparam [WIDTH:0] num_w = NUM[WIDTH:0];
   localparam [WIDTH:0] den_w = DEN[WIDTH:0];

   reg [WIDTH:0] phase; // Phase accumulator, always below DEN.
   wire [WIDTH:0] sum; // Phase after this cycle's increment.

   assign sum = phase + num_w;

   ////////////////////////////////////////////////////////////////////////
   // Phase accumulator: wrap past DEN and flag the wrap as a tick.
   always @(posedge clk) begin
      if (reset) begin
         phase <= {(WIDTH+1){1'b0}};
         tick <= 1'b0;
      end else if (sum >= den_w) begin
         // The increment crossed one full period.
         phase <= sum - den_w;
         tick <= 1'b1;
      end else begin
         // Still inside the period.
         phase <= sum;
         tick <= 1'b0;
      end
   end

endmodule // rate_tick

// File: hdl/cell_acquisition_sequencer.v
// Notes on behaviour
// - One channel per conversion, cell code into accumulator.
// - Scan converts every enabled cell, skips others.
// - Two scans per measurement, averaged to 14 bits.
// - Auxiliary channels converted once per acquisition.
// - Oversampling averages successive measurement cycles.
// - Auxiliary results never oversampled, kept 12-bit.
// - Every register word is 16 bits.
// - Twelve calibration words, read-only, fixed.
// - Calibration checksum in identity word upper byte.
// - Sequencer paced by 16 MHz oscillator enable.
// - Timers paced by separate 32,768 Hz enable.
// - Cell results left-aligned, two low bits zero; auxiliary results low-aligned.
// - Disabled cell channels read back zero.
// - Mask bits 11 to 0 select cells.
// - Mask bits 13 and 12 select auxiliaries.
`timescale 1ns/1ps
`include "cell_acquisition_sequencer_regs.vh"

module cell_acquisition_sequencer #(
   parameter [191:0] CALIB_ROM = 192'h0, // Factory words, index 0 in low bits.
   parameter [7:0] IDENTITY_LOW = 8'h5A // Arbitrary value, no meaning.
) (
   input wire CLK,
   input wire RESET,
   input wire START,
   input wire [15:0] MEASURE_ENABLE_MASK,
   input wire [2:0] OVERSAMPLE_LOG2,
   output reg CONV_START,
   output reg [3:0] CONV_CHANNEL,
   input wire CONV_DONE,
   input wire [11:0] CONV_CODE,
   output wire BUSY,
   output reg DONE,
   input wire [3:0] RESULT_SEL,
   output reg [15:0] RESULT_DATA,
   input wire [3:0] CALIB_SEL,
   output reg [15:0] CALIB_DATA,
   output wire [15:0] IDENTITY_WORD_TWO,
   output reg [15:0] TIMER_COUNT
);

   ////////////////////////////////////////////////////////////////////////
   // Constants and helper functions.

   // Sequencer states.
   localparam [1:0] ST_IDLE = 2'b00; // Waiting for a start request.
   localparam [1:0] ST_SEEK = 2'b01; // Looking for the next channel.
   localparam [1:0] ST_CONV = 2'b10; // Waiting for a conversion result.
   localparam [1:0] ST_FINISH = 2'b11; // Writing the averaged results.

   // Returns {found, index} of the lowest set mask bit at or above from.
   function [4:0] find_next;
      input [13:0] mask;
      input [3:0] from;
      integer i;
      begin
         find_next = 5'h0_00F;
         for (i = 13; i >= 0; i = i - 1) begin
            if (mask[i] && (i >= from)) begin
               find_next = {1'b1, i[3:0]};
            end
         end
      end
   endfunction

   // Scales a sum of 2^(k+1) codes to a 14-bit mean: sum * 2 / 2^k.
   // The largest sum gives 16380, so the result always fits.
   function [13:0] scale_mean;
      input [19:0] sum;
      input [2:0] k;
      reg [20:0] wide;
      begin
         wide = {sum, 1'b0} >> k;
         scale_mean = wide[13:0];
      end
   endfunction

   // Eight-bit checksum over the populated calibration words, low byte first.
   function [7:0] calib_crc;
      input [191:0] rom;
      integer b;
      integer j;
      reg [7:0] crc;
      begin
         crc = 8'h00;
         for (b = 0; b < 24; b = b + 1) begin
            crc = crc ^ rom[b*8 +: 8];
            for (j = 0; j < 8; j = j + 1) begin
               if (crc[7]) begin
                  crc = {crc[6:0], 1'b0} ^ `CALIB_CRC_POLY;
               end else begin
                  crc = {crc[6:0], 1'b0};
               end
            end
         end
         calib_crc = crc;
      end
   endfunction

   // Checksum fixed at build time from the ROM contents.
   localparam [7:0] rom_checksum = calib_crc(CALIB_ROM);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   wire fsm_tick; // One-cycle enable at the state machine rate.
   wire timer_tick; // One-cycle enable at the timer rate.
   reg [1:0] state; // Current sequencer state.
   reg start_seen; // Start request waiting for the next fsm tick.
   reg done_seen; // Conversion result waiting for the next fsm tick.
   reg [11:0] code; // Code captured with the conversion done strobe.
   reg [11:0] cell_mask; // Cell enables held for the acquisition.
   reg [1:0] aux_mask; // Auxiliary enables held for the acquisition.
   reg [2:0] ovs_log2; // Oversampling exponent held for the acquisition.
   reg [3:0] chan; // Channel search position.
   reg scan; // Second scan of the measurement cycle when set.
   reg [6:0] meas; // Measurement cycle count within the acquisition.
   reg [19:0] acc [0:11]; // Per-cell sums of all conversions.
   reg [15:0] result [0:13]; // Result words, cells then auxiliaries.
   wire [6:0] last_meas; // Index of the final measurement cycle.
   wire aux_phase; // Auxiliaries may be converted in this scan.
   wire [13:0] scan_mask; // Channels eligible in the current scan.
   wire [4:0] next_hit; // Result of the channel search.
   integer n; // Loop index over channels.

   ////////////////////////////////////////////////////////////////////////
   // Rate enables: both slow rates come from the one system clock.

   // State machine pacing at 16 MHz.
   rate_tick #(
      .NUM(`FSM_OSC_HZ),
      .DEN(`SYS_CLK_HZ),
      .WIDTH(`RATE_ACC_BITS)
   ) fsm_rate (
      .clk(CLK),
      .reset(RESET),
      .tick(fsm_tick)
   );

   // Timer pacing at 32,768 Hz, independent of the sequencer.
   rate_tick #(
      .NUM(`TIMER_OSC_HZ),
      .DEN(`SYS_CLK_HZ),
      .WIDTH(`RATE_ACC_BITS)
   ) timer_rate (
      .clk(CLK),
      .reset(RESET),
      .tick(timer_tick)
   );

   // Free-running timer advanced only by the timer enable.
   always @(posedge CLK) begin
      if (RESET) begin
         TIMER_COUNT <= `TIMER_RESET;
      end else if (timer_tick) begin
         TIMER_COUNT <= TIMER_COUNT + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel selection for the current scan.

   assign last_meas = (7'h01 << ovs_log2) - 7'h01;
   // Auxiliaries follow the second cell scan of the last cycle.
   assign aux_phase = scan && (meas == last_meas);
   // Cells only, or cells then auxiliaries in ascending order.
   assign scan_mask = aux_phase ? {aux_mask, cell_mask} : {2'b00, cell_mask};
   // Lowest enabled channel at or above the search position.
   assign next_hit = find_next(scan_mask, chan);
   assign BUSY = (state != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Request capture: a strobe arriving between fsm ticks is held.

   // A new strobe wins over the clear in the consuming cycle.
   // Once the state has moved on, a leftover flag is dropped so that a
   // strobe on the consuming edge cannot start or answer anything later.
   always @(posedge CLK) begin
      if (RESET) begin
         start_seen <= 1'b0;
         done_seen <= 1'b0;
         code <= 12'h0_000;
      end else begin
         if (START && (state == ST_IDLE)) begin
            start_seen <= 1'b1;
         end else if (fsm_tick || (state != ST_IDLE)) begin
            start_seen <= 1'b0;
         end
         if (CONV_DONE && (state == ST_CONV)) begin
            done_seen <= 1'b1;
            code <= CONV_CODE;
         end else if (fsm_tick || (state != ST_CONV)) begin
            done_seen <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: advances only on the 16 MHz enable.

   always @(posedge CLK) begin
      if (RESET) begin
         state <= ST_IDLE;
         CONV_START <= 1'b0;
         CONV_CHANNEL <= 4'h0_000;
         DONE <= 1'b0;
         cell_mask <= 12'h0_000;
         aux_mask <= 2'b00;
         ovs_log2 <= 3'h0;
         chan <= 4'h0_000;
         scan <= 1'b0;
         meas <= 7'h00;
         for (n = 0; n < `CELL_CHANNELS; n = n + 1) begin
            acc[n] <= 20'h0_0000;
         end
         for (n = 0; n < 14; n = n + 1) begin
            result[n] <= `RESULT_RESET;
         end
      end else begin
         // Both strobes last exactly one clock cycle.
         CONV_START <= 1'b0;
         DONE <= 1'b0;
         if (fsm_tick) begin
            case (state)
               ST_IDLE: begin
                  if (start_seen) begin
                     // Configuration is sampled once, here.
                     cell_mask <= MEASURE_ENABLE_MASK[`MASK_CELL_MSB:0];
                     aux_mask <= MEASURE_ENABLE_MASK[`MASK_AUX_MSB:`MASK_AUX_LSB];
                     ovs_log2 <= OVERSAMPLE_LOG2;
                     chan <= 4'h0_000;
                     scan <= 1'b0;
                     meas <= 7'h00;
                     for (n = 0; n < `CELL_CHANNELS; n = n + 1) begin
                        acc[n] <= 20'h0_0000;
                     end
                     // Auxiliary words clear; enabled ones are refilled.
                     result[12] <= `RESULT_RESET;
                     result[13] <= `RESULT_RESET;
                     state <= ST_SEEK;
                  end
               end
               ST_SEEK: begin
                  if (next_hit[4]) begin
                     // Convert exactly one channel at a time.
                     chan <= next_hit[3:0];
                     CONV_CHANNEL <= next_hit[3:0];
                     CONV_START <= 1'b1;
                     state <= ST_CONV;
                  end else if (!scan) begin
                     // First scan done; repeat for the second.
                     scan <= 1'b1;
                     chan <= 4'h0_000;
                  end else if (meas == last_meas) begin
                     state <= ST_FINISH;
                  end else begin
                     // Another measurement cycle when oversampling.
                     meas <= meas + 7'h01;
                     scan <= 1'b0;
                     chan <= 4'h0_000;
                  end
               end
               ST_CONV: begin
                  if (done_seen) begin
                     if (chan < `AUX_FIRST) begin
                        // Sum into the wide per-cell accumulator.
                        acc[chan] <= acc[chan] + {8'h00, code};
                     end else begin
                        // Single 12-bit auxiliary code, low aligned.
                        result[chan] <= {4'h0, code};
                     end
                     chan <= chan + 4'h0_001;
                     state <= ST_SEEK;
                  end
               end
               ST_FINISH: begin
                  for (n = 0; n < `CELL_CHANNELS; n = n + 1) begin
                     if (cell_mask[n]) begin
                        // Mean of all conversions, left aligned.
                        result[n] <= {scale_mean(acc[n], ovs_log2), 2'b00};
                     end else begin
                        // Disabled cells read back zero.
                        result[n] <= `RESULT_RESET;
                     end
                  end
                  DONE <= 1'b1;
                  state <= ST_IDLE;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read ports: 16-bit words, registered except the constant identity word.

   // Result and calibration reads, one cycle after the select.
   always @(posedge CLK) begin
      if (RESET) begin
         RESULT_DATA <= `RESULT_RESET;
         CALIB_DATA <= 16'h0000;
      end else begin
         if (RESULT_SEL < 4'h0_00E) begin
            RESULT_DATA <= result[RESULT_SEL];
         end else begin
            RESULT_DATA <= 16'h0000;
         end
         // Calibration comes from constants; nothing can write it.
         if (CALIB_SEL <= `CALIB_LAST_LOW) begin
            CALIB_DATA <= CALIB_ROM[CALIB_SEL*16 +: 16];
         end else if (CALIB_SEL == `CALIB_LAST_INDEX) begin
            CALIB_DATA <= CALIB_ROM[176 +: 16];
         end else begin
            CALIB_DATA <= 16'h0000;
         end
      end
   end

   // Checksum in the upper byte of the second identity word.
   assign IDENTITY_WORD_TWO = {rom_checksum, IDENTITY_LOW};

endmodule // cell_acquisition_sequencer

// File: verif/cell_acquisition_sequencer_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Port checker for the acquisition sequencer; one clock domain.
module cell_acquisition_sequencer_props (
   input logic CLK,
   input logic RESET,
   input logic START,
   input logic [15:0] MEASURE_ENABLE_MASK,
   input logic [2:0] OVERSAMPLE_LOG2,
   input logic CONV_START,
   input logic [3:0] CONV_CHANNEL,
   input logic CONV_DONE,
   input logic [11:0] CONV_CODE,
   input logic BUSY,
   input logic DONE,
   input logic [3:0] RESULT_SEL,
   input logic [15:0] RESULT_DATA,
   input logic [3:0] CALIB_SEL,
   input logic [15:0] CALIB_DATA,
   input logic [15:0] IDENTITY_WORD_TWO,
   input logic [15:0] TIMER_COUNT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////
   chk_conv_spacing: assert property (
      CONV_START |=> !CONV_START [*8]) else $error("conversion too close");
   chk_conv_in_busy: assert property (
      CONV_START |-> BUSY) else $error("conversion outside acquisition");
   chk_conv_channel: assert property (
      CONV_START |-> CONV_CHANNEL <= 4'hD) else $error("bad channel");
   chk_done_ends: assert property (
      DONE |-> !BUSY ##1 !DONE) else $error("done not a lone pulse");
   chk_start_taken: assert property (
      START && !BUSY |-> ##[0:14] BUSY) else $error("start not taken");
   chk_cell_align: assert property (
      RESULT_SEL < 4'hC |=> RESULT_DATA[1:0] == 2'b00)
      else $error("cell result low bits set");
   chk_aux_width: assert property (
      RESULT_SEL >= 4'hC |=> RESULT_DATA[15:12] == 4'h0)
      else $error("aux result wider than code");
   chk_calib_gap: assert property (
      CALIB_SEL > 4'hA && CALIB_SEL < 4'hF |=> CALIB_DATA == 16'h0000)
      else $error("unpopulated calibration word not zero");
   chk_id_fixed: assert property (
      $stable(IDENTITY_WORD_TWO)) else $error("identity word moved");
   chk_timer_step: assert property (
      !$stable(TIMER_COUNT) |-> TIMER_COUNT == $past(TIMER_COUNT) + 16'h0001)
      else $error("timer jumped");
   // Coverage of the main traffic.
   cov_done: cover property (DONE);
   cov_aux_last: cover property (CONV_START && CONV_CHANNEL == 4'hD);
   cov_refused: cover property (START && BUSY);
endmodule // cell_acquisition_sequencer_props

bind cell_acquisition_sequencer cell_acquisition_sequencer_props u_props (
   .CLK(CLK), .RESET(RESET), .START(START),
   .MEASURE_ENABLE_MASK(MEASURE_ENABLE_MASK),
   .OVERSAMPLE_LOG2(OVERSAMPLE_LOG2), .CONV_START(CONV_START),
   .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE),
   .CONV_CODE(CONV_CODE), .BUSY(BUSY), .DONE(DONE),
   .RESULT_SEL(RESULT_SEL), .RESULT_DATA(RESULT_DATA),
   .CALIB_SEL(CALIB_SEL), .CALIB_DATA(CALIB_DATA),
   .IDENTITY_WORD_TWO(IDENTITY_WORD_TWO), .TIMER_COUNT(TIMER_COUNT));

// File: verif/cell_acquisition_sequencer_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Self-checking bench; it also plays the converter.
module cell_acquisition_sequencer_tb;
   localparam [191:0] ROM =
      192'h1234_5678_9ABC_DEF0_0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
   localparam [7:0] ID_LOW = 8'hC3; // Arbitrary value, no meaning.
   logic CLK, RESET, START, CONV_DONE, CONV_START, BUSY, DONE;
   logic [15:0] MEASURE_ENABLE_MASK, RESULT_DATA, CALIB_DATA;
   logic [15:0] IDENTITY_WORD_TWO, TIMER_COUNT;
   logic [2:0] OVERSAMPLE_LOG2;
   logic [11:0] CONV_CODE;
   logic [3:0] RESULT_SEL, CALIB_SEL, CONV_CHANNEL;
   integer fail_count = 0; // Mismatches seen.
   integer samples_checked = 0; // Comparisons made.
   integer sum [0:13]; // Codes handed out per channel.
   integer nconv = 0; // Conversions served.
   logic [3:0] q [$]; // Channels expected, in order.

   cell_acquisition_sequencer #(.CALIB_ROM(ROM), .IDENTITY_LOW(ID_LOW)) dut (
      .CLK(CLK), .RESET(RESET), .START(START),
      .MEASURE_ENABLE_MASK(MEASURE_ENABLE_MASK),
      .OVERSAMPLE_LOG2(OVERSAMPLE_LOG2), .CONV_START(CONV_START),
      .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE),
      .CONV_CODE(CONV_CODE), .BUSY(BUSY), .DONE(DONE),
      .RESULT_SEL(RESULT_SEL), .RESULT_DATA(RESULT_DATA),
      .CALIB_SEL(CALIB_SEL), .CALIB_DATA(CALIB_DATA),
      .IDENTITY_WORD_TWO(IDENTITY_WORD_TWO), .TIMER_COUNT(TIMER_COUNT));

   // The 200 MHz clock.
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////
   // Compares one word and counts it.
   task chk(input string name, input logic [15:0] e, input logic [15:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask

   // Checksum worked out independently of the design.
   function automatic [7:0] crc8(input [191:0] r);
      reg [7:0] c;
      integer i, b;
      c = 8'h00;
      for (i = 0; i < 24; i = i + 1) begin
         c = c ^ r[8*i +: 8];
         for (b = 0; b < 8; b = b + 1) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   // Reads one result word and one calibration word together.
   task rd(input logic [3:0] sel, output logic [15:0] r, output logic [15:0] c);
      RESULT_SEL = sel;
      CALIB_SEL = sel;
      @(posedge CLK);
      #1 r = RESULT_DATA;
      c = CALIB_DATA;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Converter stand-in with a latency that varies from 1 to 5 cycles.
   initial begin : converter
      logic [15:0] e;
      forever begin
         @(posedge CLK);
         #1;
         if (CONV_START === 1'b1) begin
            e = q.size() ? {12'h000, q.pop_front()} : 16'hFFFF;
            chk("channel", e, {12'h000, CONV_CHANNEL});
            repeat (1 + nconv % 5) @(posedge CLK);
            #1 CONV_DONE = 1'b1;
            CONV_CODE = {CONV_CHANNEL, nconv[7:0]};
            sum[CONV_CHANNEL] = sum[CONV_CHANNEL] + CONV_CODE;
            nconv = nconv + 1;
            @(posedge CLK);
            #1 CONV_DONE = 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Reset values, calibration words and identity word.
   task t_reset;
      logic [15:0] r, c, e;
      integer i;
      for (i = 0; i < 16; i = i + 1) begin
         rd(i[3:0], r, c);
         e = (i < 11) ? ROM[16*i +: 16] : 16'h0000;
         if (i == 15) e = ROM[191:176];
         chk("result after reset", 16'h0000, r);
         chk("calib word", e, c);
      end
      chk("identity", {crc8(ROM), ID_LOW}, IDENTITY_WORD_TWO);
      $display("t_reset finished");
   endtask

   // One acquisition with a refused start and a config change mid-run.
   task t_acq(input logic [15:0] m, input logic [2:0] k);
      logic [15:0] r, c, e;
      integer i, s, n, t;
      for (i = 0; i < 14; i = i + 1) sum[i] = 0;
      for (n = 0; n < (1 << k); n = n + 1) begin
         for (s = 0; s < 24; s = s + 1) begin
            if (m[s % 12]) q.push_back(s % 12);
         end
      end
      if (m[12]) q.push_back(4'hC);
      if (m[13]) q.push_back(4'hD);
      MEASURE_ENABLE_MASK = m;
      OVERSAMPLE_LOG2 = k;
      START = 1'b1;
      @(posedge CLK);
      #1 START = 1'b0;
      repeat (20) @(posedge CLK);
      #1 START = 1'b1;
      MEASURE_ENABLE_MASK = ~m;
      OVERSAMPLE_LOG2 = ~k;
      @(posedge CLK);
      #1 START = 1'b0;
      n = 0;
      while (DONE !== 1'b1 && n < 40000) begin
         @(posedge CLK);
         #1 n = n + 1;
      end
      chk("done seen", 16'h0001, {15'h0000, DONE});
      chk("conversions left", 16'h0000, 16'(q.size()));
      repeat (20) @(posedge CLK);
      #1 chk("busy after refusal", 16'h0000, {15'h0000, BUSY});
      for (i = 0; i < 16; i = i + 1) begin
         rd(i[3:0], r, c);
         e = 16'h0000;
         t = (i < 14) ? sum[i] : 0;
         if (i < 12 && m[i]) begin
            t = (t * 2) >> k;
            e = {t[13:0], 2'b00};
         end
         if (i >= 12 && m[i]) e = {4'h0, t[11:0]};
         chk("result", e, r);
      end
      $display("t_acq finished for mask %h", m);
   endtask

   // Timer advances by one on each slow tick, 6103 or 6104 cycles apart.
   task t_timer;
      logic [15:0] t0;
      integer n, j;
      for (j = 0; j < 2; j = j + 1) begin
         t0 = TIMER_COUNT;
         n = 0;
         while (TIMER_COUNT === t0 && n < 7000) begin
            @(posedge CLK);
            #1 n = n + 1;
         end
      end
      chk("timer step", t0 + 16'h0001, TIMER_COUNT);
      chk("timer period", 16'h0001, {15'h0000, n == 6103 || n == 6104});
      $display("t_timer finished");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops.
   task test_done;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Cuts a hang short: the tests need about 18,000 cycles, this is 80,000.
   initial begin
      #400000;
      fail_count = fail_count + 1;
      $display("[FAIL] run expected finish seen timeout");
      test_done;
   end

   // Main sequence.
   initial begin
      RESET = 1'b1;
      START = 1'b0;
      MEASURE_ENABLE_MASK = 16'h0000;
      OVERSAMPLE_LOG2 = 3'h0;
      CONV_DONE = 1'b0;
      CONV_CODE = 12'h000;
      RESULT_SEL = 4'h0;
      CALIB_SEL = 4'h0;
      repeat (3) @(posedge CLK);
      #1 RESET = 1'b0;
      t_reset;
      t_acq(16'h3FFF, 3'h0);
      t_acq(16'h1005, 3'h2);
      t_acq(16'hC800, 3'h7);
      t_acq(16'h2A50, 3'h1);
      t_timer;
      test_done;
   end
endmodule // cell_acquisition_sequencer_tb
